/* hdl/limit_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module limit_counter (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire logic step_i,
   input wire logic [15:0] limit_i,
   output logic [15:0] count_o,
   output logic at_limit_o
);
   logic [15:0] count_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_r <= 16'h0000;
      end else if (clear_i) begin
         count_r <= 16'h0000;
      end else if (step_i) begin
         count_r <= 16'(count_r + 16'h0001);
      end
   end

   assign count_o = count_r;
   assign at_limit_o = (count_r == limit_i);
endmodule
`default_nettype wire

/* hdl/trigger_pulse_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module trigger_pulse_gen (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic fire_i,
   input wire logic [12:0] mask_i,
   input wire logic toggle_i,
   input wire logic [3:0] width_i,
   output logic [12:0] out_o
);
   logic [12:0] out_r;
   logic [3:0] cnt_r;

   // One shared width counter: all targets of a broadcast start and end together
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_r <= 13'h0000;
         cnt_r <= 4'h0;
      end else if (fire_i) begin
         if (toggle_i) begin
            out_r <= out_r ^ mask_i;
         end else begin
            out_r <= mask_i;
            cnt_r <= width_i;
         end
      end else if (!toggle_i && (out_r != 13'h0000)) begin
         if (cnt_r == 4'h0) begin
            out_r <= 13'h0000; // RQ13
         end else begin
            cnt_r <= 4'(cnt_r - 4'h1);
         end
      end
   end

   assign out_o = out_r;
endmodule
`default_nettype wire

/* hdl/trigger_sequencer_limit_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module trigger_sequencer_limit_regs (
   input wire logic REF_CLK_I,
   input wire logic RESET_I,
   input wire trigger_sequencer_pkg::reg_req_t REG_REQ_I,
   output logic [15:0] REG_RDATA_O,
   input wire trigger_sequencer_pkg::step_req_t STEP_I,
   output logic STEP_BUSY_O,
   output logic STEP_DONE_O,
   output trigger_sequencer_pkg::jump_ans_t JUMP_O,
   output trigger_sequencer_pkg::trig_out_t TRIG_O
);
   import trigger_sequencer_pkg::*;

   // ************************************************
   // Declarations
   // ************************************************
   logic [15:0] ctrl_r;
   logic [BTE_W-1:0] bte_r;
   logic [15:0] t0_lim_r;
   logic [15:0] t1_lim_r;
   logic [15:0] sd_lim_r;
   logic [15:0] c0_lim_r;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic done_r;
   jump_ans_t jump_r;
   seq_state_t state_r;
   seq_state_t state_nxt;
   logic wait_sel_r;
   logic locked;
   logic toggle_mode;
   logic visible;
   logic [PWD_W-1:0] pulse_width;
   logic step_any;
   logic accept;
   logic bcast_fire;
   logic wr_ok;
   logic [15:0] tmr0_count;
   logic [15:0] tmr1_count;
   logic [15:0] dly_count;
   logic [15:0] c0_count;
   logic tmr0_hit;
   logic tmr1_hit;
   logic dly_hit;
   logic c0_hit;
   logic wait_done;
   logic [12:0] trig_bits;

   assign locked = ctrl_r[CTL_ENABLE_BIT] & ctrl_r[CTL_START_BIT];
   assign toggle_mode = ctrl_r[CTL_TOGGLE_BIT];
   assign visible = ctrl_r[CTL_VIS_BIT];
   assign pulse_width = ctrl_r[CTL_PWD_LSB +: PWD_W];

   // ************************************************
   // Register writes
   // ************************************************
   // Limits can only be changed while the sequencer is stopped
   assign wr_ok = REG_REQ_I.wr && !locked; // RQ6

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         ctrl_r <= REG_RESET;
      end else if (REG_REQ_I.wr && addr_is(REG_REQ_I.addr, OFS_CONTROL)) begin
         ctrl_r <= 16'h0000;
         ctrl_r[CTL_ENABLE_BIT] <= REG_REQ_I.wdata[CTL_ENABLE_BIT];
         ctrl_r[CTL_TOGGLE_BIT] <= REG_REQ_I.wdata[CTL_TOGGLE_BIT];
         ctrl_r[CTL_VIS_BIT] <= REG_REQ_I.wdata[CTL_VIS_BIT];
         ctrl_r[CTL_START_BIT] <= REG_REQ_I.wdata[CTL_START_BIT];
         ctrl_r[CTL_PWD_LSB +: PWD_W] <= REG_REQ_I.wdata[CTL_PWD_LSB +: PWD_W];
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         bte_r <= REG_RESET[BTE_W-1:0]; // RQ11
      end else if (wr_ok && addr_is(REG_REQ_I.addr, OFS_BROADCAST)) begin
         bte_r <= REG_REQ_I.wdata[BTE_W-1:0];
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         t0_lim_r <= REG_RESET;
         t1_lim_r <= REG_RESET;
         sd_lim_r <= REG_RESET;
         c0_lim_r <= REG_RESET;
      end else if (wr_ok) begin
         if (addr_is(REG_REQ_I.addr, OFS_TIMER0)) begin
            t0_lim_r <= REG_REQ_I.wdata;
         end
         if (addr_is(REG_REQ_I.addr, OFS_TIMER1)) begin
            t1_lim_r <= REG_REQ_I.wdata;
         end
         if (addr_is(REG_REQ_I.addr, OFS_STEP_DELAY)) begin
            sd_lim_r <= REG_REQ_I.wdata;
         end
         if (addr_is(REG_REQ_I.addr, OFS_COUNTER0)) begin
            c0_lim_r <= REG_REQ_I.wdata;
         end
      end
   end

   // ************************************************
   // Register reads
   // ************************************************
   always_comb begin
      rdata_nxt = 16'h0000;
      unique case (REG_REQ_I.addr)
         OFS_CONTROL: rdata_nxt = ctrl_r;
         OFS_BROADCAST: rdata_nxt = {3'h0, bte_r}; // RQ11
         OFS_TIMER0: rdata_nxt = visible ? tmr0_count : t0_lim_r; // RQ12
         OFS_TIMER1: rdata_nxt = visible ? tmr1_count : t1_lim_r; // RQ12
         OFS_STEP_DELAY: rdata_nxt = visible ? dly_count : sd_lim_r; // RQ12
         OFS_COUNTER0: rdata_nxt = visible ? c0_count : c0_lim_r; // RQ12
         OFS_STATUS: begin
            rdata_nxt[STS_BUSY_BIT] = (state_r != ST_IDLE);
            rdata_nxt[STS_WAIT_BIT] = (state_r == ST_WAIT);
         end
         default: rdata_nxt = 16'h0000;
      endcase
   end

   // Read data stand for exactly the cycle after the strobe
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         rdata_r <= 16'h0000;
      end else if (REG_REQ_I.rd) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= 16'h0000;
      end
   end

   assign REG_RDATA_O = rdata_r;

   // ************************************************
   // Step sequencing
   // ************************************************
   // Steps offered while busy or stopped are dropped; the decoder must watch busy
   assign step_any = STEP_I.ctrl | STEP_I.wait_t0 | STEP_I.wait_t1 | STEP_I.jump_c0;
   assign accept = step_any && locked && (state_r == ST_IDLE);
   assign bcast_fire = accept && STEP_I.ctrl && (STEP_I.option == OPTION_BROADCAST); // RQ5
   assign wait_done = wait_sel_r ? tmr1_hit : tmr0_hit;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (accept) begin
               state_nxt = (STEP_I.wait_t0 || STEP_I.wait_t1) ? ST_WAIT : ST_DELAY;
            end
         end
         ST_WAIT: begin
            if (wait_done) begin
               state_nxt = ST_DELAY; // RQ7 RQ8
            end
         end
         ST_DELAY: begin
            if (dly_hit) begin
               state_nxt = ST_IDLE; // RQ9
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         wait_sel_r <= 1'b0;
      end else if (accept) begin
         wait_sel_r <= STEP_I.wait_t1;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         done_r <= 1'b0;
      end else begin
         done_r <= (state_r == ST_DELAY) && dly_hit;
      end
   end

   assign STEP_BUSY_O = (state_r != ST_IDLE);
   assign STEP_DONE_O = done_r;

   // ************************************************
   // Timers and counters
   // ************************************************
   limit_counter u_timer0 (
      .clk_i(REF_CLK_I),
      .rst_i(RESET_I),
      .clear_i(accept && STEP_I.wait_t0),
      .step_i((state_r == ST_WAIT) && !wait_sel_r),
      .limit_i(t0_lim_r),
      .count_o(tmr0_count),
      .at_limit_o(tmr0_hit)
   );

   limit_counter u_timer1 (
      .clk_i(REF_CLK_I),
      .rst_i(RESET_I),
      .clear_i(accept && STEP_I.wait_t1),
      .step_i((state_r == ST_WAIT) && wait_sel_r),
      .limit_i(t1_lim_r),
      .count_o(tmr1_count),
      .at_limit_o(tmr1_hit)
   );

   // Counting from zero up to the limit gives limit plus one clocks of delay
   limit_counter u_step_delay (
      .clk_i(REF_CLK_I),
      .rst_i(RESET_I),
      .clear_i(state_nxt == ST_DELAY && state_r != ST_DELAY),
      .step_i(state_r == ST_DELAY),
      .limit_i(sd_lim_r),
      .count_o(dly_count),
      .at_limit_o(dly_hit)
   );

   // Loop count: taken while below the limit, wraps to zero on the final pass
   limit_counter u_counter0 (
      .clk_i(REF_CLK_I),
      .rst_i(RESET_I),
      .clear_i(accept && STEP_I.jump_c0 && c0_hit),
      .step_i(accept && STEP_I.jump_c0 && !c0_hit),
      .limit_i(c0_lim_r),
      .count_o(c0_count),
      .at_limit_o(c0_hit)
   );

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         jump_r <= '0;
      end else begin
         jump_r.valid <= accept && STEP_I.jump_c0;
         jump_r.taken <= accept && STEP_I.jump_c0 && !c0_hit; // RQ10
      end
   end

   assign JUMP_O = jump_r;

   // ************************************************
   // Broadcast triggers
   // ************************************************
   // Mask taken at the accepting edge so every target starts in one cycle
   trigger_pulse_gen u_pulses (
      .clk_i(REF_CLK_I),
      .rst_i(RESET_I),
      .fire_i(bcast_fire),
      .mask_i(bte_r), // RQ1 RQ2 RQ3 RQ4 RQ14
      .toggle_i(toggle_mode),
      .width_i(pulse_width),
      .out_o(trig_bits)
   );

   assign TRIG_O = trig_out_t'(trig_bits);

   // ************************************************
   // Checks
   // ************************************************
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RESET_I);

   sequence s_single_pulse;
      (TRIG_O == $past(bte_r)) ##1 (TRIG_O == 13'h0000);
   endsequence

   // A four-clock pulse is only judged when no later broadcast restarts it
   sequence s_fire_width3;
      bcast_fire && !toggle_mode && pulse_width == 4'h3 && bte_r[12];
   endsequence

   sequence s_quiet4;
      (!bcast_fire && !toggle_mode) [*4];
   endsequence

   sequence s_step_taken;
      accept;
   endsequence

   a_bcast_targets: assert property (bcast_fire && !toggle_mode |=> TRIG_O == $past(bte_r)) // RQ1
      else $error("broadcast outputs differ from enable mask");
   a_other_option: assert property (accept && !bcast_fire && TRIG_O == 13'h0000 |=> TRIG_O == 13'h0000) // RQ5
      else $error("non-broadcast step produced trigger");
   a_locked_write: assert property (locked && REG_REQ_I.wr |=> $stable(bte_r) && $stable(sd_lim_r)) // RQ6
      else $error("limit register changed while running");
   a_pulse_width: assert property (bcast_fire && !toggle_mode && pulse_width == 4'h0 && !$past(bcast_fire) // RQ13
      |=> s_single_pulse)
      else $error("one-clock trigger pulse has wrong length");
   a_delay_base: assert property (state_r == ST_DELAY && $past(state_r) != ST_DELAY && sd_lim_r == 16'h0000 // RQ9
      |=> STEP_DONE_O && !STEP_BUSY_O)
      else $error("zero step delay not one clock");
   a_timer0_end: assert property ((state_r == ST_WAIT) && !wait_sel_r && tmr0_count == t0_lim_r // RQ7
      |=> state_r == ST_DELAY)
      else $error("timer0 wait did not end at limit");
   a_timer1_end: assert property ((state_r == ST_WAIT) && wait_sel_r && tmr1_count == t1_lim_r // RQ8
      |=> state_r == ST_DELAY)
      else $error("timer1 wait did not end at limit");
   a_jump_loop: assert property (accept && STEP_I.jump_c0 // RQ10
      |=> JUMP_O.valid && (JUMP_O.taken == !$past(c0_hit)))
      else $error("jump answer disagrees with counter0 limit");
   a_unused_zero: assert property (REG_REQ_I.rd && addr_is(REG_REQ_I.addr, OFS_BROADCAST) // RQ11
      |=> REG_RDATA_O == {3'h0, $past(bte_r)})
      else $error("unimplemented broadcast bits read nonzero");
   a_limit_view: assert property (REG_REQ_I.rd && addr_is(REG_REQ_I.addr, OFS_TIMER0) && !visible // RQ12
      |=> REG_RDATA_O == $past(t0_lim_r))
      else $error("hidden read did not return stored limit");

   // ************************************************
   // Register, step and pulse checks
   // ************************************************
   a_live_view: assert property (REG_REQ_I.rd && addr_is(REG_REQ_I.addr, OFS_COUNTER0) && visible // RQ12
      |=> REG_RDATA_O == $past(c0_count))
      else $error("visible read did not return live counter0");
   a_locked_others: assert property (locked && REG_REQ_I.wr |=> $stable(t0_lim_r) && $stable(c0_lim_r)) // RQ6
      else $error("timer0 or counter0 limit changed while running");
   a_pulse_four: assert property (s_fire_width3 ##1 s_quiet4 // RQ13
      |-> ($past(TRIG_O.adc_sample_trigger, 3) && TRIG_O.adc_sample_trigger) ##1 !TRIG_O.adc_sample_trigger)
      else $error("four-clock trigger pulse has wrong length");
   a_toggle_flip: assert property (bcast_fire && toggle_mode // RQ14
      |=> trig_bits == ($past(trig_bits) ^ $past(bte_r)))
      else $error("toggle broadcast did not flip selected targets");
   a_toggle_hold: assert property (!bcast_fire && toggle_mode |=> $stable(trig_bits)) // RQ5
      else $error("toggle outputs changed without a broadcast");
   // Without a broadcast a pulse may only end, never start
   a_no_stray: assert property (!bcast_fire && !toggle_mode |=> (trig_bits & ~$past(trig_bits)) == 13'h0000) // RQ5
      else $error("trigger rose without a broadcast");
   a_step_busy: assert property (s_step_taken |=> STEP_BUSY_O) // RQ9
      else $error("accepted step did not raise busy");
   a_delay_end: assert property (state_r == ST_DELAY && dly_count == sd_lim_r // RQ9
      |=> STEP_DONE_O && !STEP_BUSY_O)
      else $error("step delay did not end at its limit");
   a_done_single: assert property (STEP_DONE_O |=> !STEP_DONE_O) // RQ9
      else $error("step done held longer than one clock");
endmodule
`default_nettype wire

/* hdl/trigger_sequencer_pkg.sv */
// Contract
// (RQ1) Broadcast with bit 12 set fires ADC trigger
// (RQ2) Bits 11..8 pulse selected capture units
// (RQ3) Bits 7..4 clock selected compare units
// (RQ4) Bits 3..0 pulse selected compare units
// (RQ5) Only control option 1111 uses broadcast
// (RQ6) Enable and start lock limit registers
// (RQ7) Timer0 limit ends wait-timer0 step
// (RQ8) Timer1 limit ends wait-timer1 step
// (RQ9) Step delay lasts stored value plus one
// (RQ10) Counter0 limit sets jump loop count
// (RQ11) Unused bits read zero; reset clears all
// (RQ12) Visibility bit reads live counter values
// (RQ13) Pulse lasts width field plus one clocks
// (RQ14) Broadcast bits sampled once at step start
package trigger_sequencer_pkg;

   // ************************************************
   // Register map
   // ************************************************
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 16;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_BROADCAST = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_TIMER0 = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_TIMER1 = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_STEP_DELAY = 3'h4;
   localparam logic [ADDR_W-1:0] OFS_COUNTER0 = 3'h5;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h6;
   localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

   // ************************************************
   // Field positions
   // ************************************************
   localparam int unsigned BTE_W = 13;
   localparam int unsigned CTL_ENABLE_BIT = 15;
   localparam int unsigned CTL_TOGGLE_BIT = 12;
   localparam int unsigned CTL_VIS_BIT = 8;
   localparam int unsigned CTL_START_BIT = 7;
   localparam int unsigned CTL_PWD_LSB = 0;
   localparam int unsigned PWD_W = 4;
   localparam int unsigned STS_BUSY_BIT = 0;
   localparam int unsigned STS_WAIT_BIT = 1;
   localparam logic [3:0] OPTION_BROADCAST = 4'hF;

   // ************************************************
   // Types
   // ************************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic ctrl;
      logic [3:0] option;
      logic wait_t0;
      logic wait_t1;
      logic jump_c0;
   } step_req_t;

   // Bit order matches the broadcast register bits 12..0
   typedef struct packed {
      logic adc_sample_trigger;
      logic [3:0] capture_sync;
      logic [3:0] compare_clock;
      logic [3:0] compare_sync;
   } trig_out_t;

   typedef struct packed {
      logic valid;
      logic taken;
   } jump_ans_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_DELAY = 2'b10
   } seq_state_t;

   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction

endpackage

/* test/trig_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module trig_sink (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic clear_i,
   input wire trigger_sequencer_pkg::trig_out_t trig_i,
   output logic [12:0] seen_o,
   output logic [4:0] hi_count_o
);
   import trigger_sequencer_pkg::*;

   // ************************************************
   // Target bookkeeping
   // ************************************************
   // Sticky per target: a receiving unit reacts to any pulse since the last clear
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         seen_o <= '0;
      end else begin
         seen_o <= seen_o | trig_i;
      end
   end

   // Width of the ADC trigger pulse, saturating so a stuck output cannot wrap
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         hi_count_o <= '0;
      end else if (trig_i.adc_sample_trigger && hi_count_o != 5'h1F) begin
         hi_count_o <= hi_count_o + 5'h01;
      end
   end
endmodule
`default_nettype wire

/* test/trigger_sequencer_limit_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module trigger_sequencer_limit_regs_tb;
   import trigger_sequencer_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   reg_req_t req = '0;
   step_req_t stp = '0;
   logic snk_clr = 1'b0;
   logic [15:0] rdata;
   logic busy;
   logic done;
   jump_ans_t jmp;
   trig_out_t trig;
   logic [12:0] seen;
   logic [4:0] hi12;
   logic [12:0] trig_c1;
   jump_ans_t jmp_c1;
   logic busy_c1;
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int cyc;

   always #10 clk = ~clk;

   trigger_sequencer_limit_regs i_trigger_sequencer_limit_regs (.REF_CLK_I(clk), .RESET_I(rst),
      .REG_REQ_I(req), .REG_RDATA_O(rdata), .STEP_I(stp), .STEP_BUSY_O(busy), .STEP_DONE_O(done),
      .JUMP_O(jmp), .TRIG_O(trig));
   trig_sink i_trig_sink (.clk_i(clk), .rst_i(rst), .clear_i(snk_clr), .trig_i(trig),
      .seen_o(seen), .hi_count_o(hi12));

   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic close_out;
      $display("TB: %0d compared, %0d mismatches", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen_v, input logic [15:0] exp_v);
      n_compared++;
      if (seen_v !== exp_v) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp_v, seen_v);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= '0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input string what, input logic [2:0] a, input logic [15:0] e);
      @(posedge clk);
      req <= '{1'b0, 1'b1, a, 16'h0000};
      @(posedge clk);
      req <= '0;
      #1;
      check(what, rdata, e);
   endtask

   // Cycle 1 is the cycle after the edge that takes the step
   task automatic run_step(input step_req_t s, output int n);
      @(posedge clk);
      stp <= s;
      snk_clr <= 1'b1;
      @(posedge clk);
      stp <= '0;
      snk_clr <= 1'b0;
      #1;
      trig_c1 = trig;
      jmp_c1 = jmp;
      busy_c1 = busy;
      n = 1;
      while (done !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   // ************************************************
   // Scenarios
   // ************************************************
   task automatic t_reset_map;
      for (int a = 0; a < 7; a++) begin
         rd_chk("reset value", 3'(a), 16'h0000);
      end
      wr(OFS_BROADCAST, 16'hFFFF);
      rd_chk("broadcast unused bits", OFS_BROADCAST, 16'h1FFF);
      for (int a = 2; a < 6; a++) begin
         wr(3'(a), 16'hA5C3);
         rd_chk("limit store", 3'(a), 16'hA5C3);
      end
      wr(3'h7, 16'hFFFF);
      rd_chk("unmapped", 3'h7, 16'h0000);
      $display("test reset_map done");
   endtask

   task automatic t_broadcast;
      logic [12:0] m [4] = '{13'h1000, 13'h0F00, 13'h00F0, 13'h000F};
      for (int a = 2; a < 6; a++) begin
         wr(3'(a), 16'h0000);
      end
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CONTROL, 16'h0000);
         wr(OFS_BROADCAST, {3'b000, m[i]});
         wr(OFS_CONTROL, 16'h8080);
         run_step('{1'b1, OPTION_BROADCAST, 1'b0, 1'b0, 1'b0}, cyc);
         check("targets at once", 16'(trig_c1), 16'(m[i]));
         check("broadcast done", 16'(cyc), 16'h0002);
         repeat (3) @(posedge clk);
         check("targets seen", 16'(seen), 16'(m[i]));
         wr(OFS_BROADCAST, 16'h1FFF);
         wr(OFS_TIMER0, 16'h0077);
         rd_chk("locked broadcast", OFS_BROADCAST, 16'(m[i]));
         rd_chk("locked timer0", OFS_TIMER0, 16'h0000);
      end
      $display("test broadcast done");
   endtask

   task automatic t_other_options;
      wr(OFS_CONTROL, 16'h0000);
      wr(OFS_BROADCAST, 16'h1FFF);
      wr(OFS_CONTROL, 16'h8080);
      for (int o = 0; o < 15; o++) begin
         run_step('{1'b1, 4'(o), 1'b0, 1'b0, 1'b0}, cyc);
         check("option done", 16'(cyc), 16'h0002);
         repeat (2) @(posedge clk);
         check("no pulse", 16'(seen), 16'h0000);
      end
      $display("test other_options done");
   endtask

   task automatic t_width;
      logic [3:0] w [3] = '{4'h0, 4'h3, 4'hF};
      for (int i = 0; i < 3; i++) begin
         wr(OFS_CONTROL, {12'h808, w[i]});
         run_step('{1'b1, OPTION_BROADCAST, 1'b0, 1'b0, 1'b0}, cyc);
         repeat (20) @(posedge clk);
         check("pulse width", 16'(hi12), 16'(w[i]) + 16'h0001);
      end
      $display("test width done");
   endtask

   task automatic t_toggle;
      wr(OFS_CONTROL, 16'h0000);
      wr(OFS_BROADCAST, 16'h1011);
      wr(OFS_CONTROL, 16'h9080);
      for (int i = 0; i < 2; i++) begin
         run_step('{1'b1, OPTION_BROADCAST, 1'b0, 1'b0, 1'b0}, cyc);
         check("toggle at once", 16'(trig_c1), (i == 0) ? 16'h1011 : 16'h0000);
         repeat (4) @(posedge clk);
         #1;
         check("toggle level", 16'(trig), (i == 0) ? 16'h1011 : 16'h0000);
      end
      wr(OFS_CONTROL, 16'h8080);
      $display("test toggle done");
   endtask

   task automatic t_delays;
      wr(OFS_CONTROL, 16'h0000);
      wr(OFS_STEP_DELAY, 16'h0003);
      wr(OFS_TIMER0, 16'h0002);
      wr(OFS_TIMER1, 16'h0004);
      wr(OFS_CONTROL, 16'h8080);
      run_step('{1'b1, 4'h0, 1'b0, 1'b0, 1'b0}, cyc);
      check("delay done", 16'(cyc), 16'h0005);
      check("busy in step", 16'(busy_c1), 16'h0001);
      check("idle at done", 16'(busy), 16'h0000);
      run_step('{1'b0, 4'h0, 1'b1, 1'b0, 1'b0}, cyc);
      check("timer0 done", 16'(cyc), 16'h0008);
      run_step('{1'b0, 4'h0, 1'b0, 1'b1, 1'b0}, cyc);
      check("timer1 done", 16'(cyc), 16'h000A);
      $display("test delays done");
   endtask

   task automatic t_jump;
      wr(OFS_CONTROL, 16'h0000);
      wr(OFS_STEP_DELAY, 16'h0000);
      wr(OFS_COUNTER0, 16'h0002);
      wr(OFS_CONTROL, 16'h8080);
      run_step('{1'b0, 4'h0, 1'b0, 1'b0, 1'b1}, cyc);
      check("jump 1", 16'(jmp_c1), 16'h0003);
      wr(OFS_CONTROL, 16'h8180);
      rd_chk("live counter0", OFS_COUNTER0, 16'h0001);
      wr(OFS_CONTROL, 16'h8080);
      rd_chk("stored counter0", OFS_COUNTER0, 16'h0002);
      run_step('{1'b0, 4'h0, 1'b0, 1'b0, 1'b1}, cyc);
      check("jump 2", 16'(jmp_c1), 16'h0003);
      run_step('{1'b0, 4'h0, 1'b0, 1'b0, 1'b1}, cyc);
      check("jump at limit", 16'(jmp_c1), 16'h0002);
      check("jump done", 16'(cyc), 16'h0002);
      $display("test jump done");
   endtask

   // ************************************************
   // Main sequence and hang guard
   // ************************************************
   // Ceiling well above the roughly 400 cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         close_out();
      end
   end

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset_map();
      t_broadcast();
      t_other_options();
      t_width();
      t_toggle();
      t_delays();
      t_jump();
      close_out();
   end
endmodule
`default_nettype wire
